// *** logic/way_sram_cfg.svh ***
// Timing counts and field constants for the way-select cache SRAM host
`ifndef WAY_SRAM_CFG_SVH
`define WAY_SRAM_CFG_SVH
`define ADDR_W          13
`define DATA_W          16
`define BANK_BIT        12
`define LOW_LANE_LSB    0
`define HIGH_LANE_LSB   8
`define CLK_PERIOD_NS   10
`define ADDR_SETUP_NS   8
`define ADDR_HOLD_NS    4
`define ACCESS_NS       45
`define WRITE_PULSE_NS  30
`define DATA_SETUP_NS   10
`define ADDR_SETUP_CYC  ((`ADDR_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDR_HOLD_CYC   ((`ADDR_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACCESS_CYC      ((`ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_PULSE_CYC ((`WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W           4
`endif

// *** logic/way_sram_pkg.sv ***
// Types shared by the way-select cache SRAM host
package way_sram_pkg;
   typedef enum logic [5:0] {
      st_idle    = 6'b00_0001,
      st_setup   = 6'b00_0010,
      st_hold    = 6'b00_0100,
      st_read    = 6'b00_1000,
      st_write   = 6'b01_0000,
      st_release = 6'b10_0000
   } state_type;
endpackage

// *** logic/way_strobe_if.sv ***
// Strobe bundle between sequencer and way decoder
`timescale 1ns/100ps
interface way_strobe_if;
   logic       two_way;
   logic       way_b;
   logic       bank_bit;
   logic       do_read;
   logic       do_write;
   logic       collide;
   logic [1:0] we_n;
   logic [1:0] oe_n;
   modport seq (output two_way, way_b, bank_bit, do_read, do_write, collide,
                input we_n, oe_n);
   modport dec (input two_way, way_b, bank_bit, do_read, do_write, collide,
                output we_n, oe_n);
endinterface

// *** logic/way_strobe_decode.sv ***
// Decodes way write and output strobes from mode and operation
`timescale 1ns/100ps
module way_strobe_decode (
   way_strobe_if.dec s
);
   wire joined_w;
   wire joined_r;
   wire sel_b;
   // Direct mode joins the strobes; bank bit picks the half on the device
   assign sel_b    = s.two_way & s.way_b;
   assign joined_w = s.do_write;
   assign joined_r = s.do_read & ~s.collide;
   assign s.we_n[0] = s.two_way ? ~(s.do_write & ~sel_b) : ~joined_w;
   assign s.we_n[1] = s.two_way ? ~(s.do_write & sel_b)  : ~joined_w;
   // In two-way mode collide forces both enables low together to exercise deselect; in direct mode it holds both high
   assign s.oe_n[0] = s.two_way ? ~((s.do_read & ~sel_b) | s.collide)
                                : ~joined_r;
   assign s.oe_n[1] = s.two_way ? ~((s.do_read & sel_b) | s.collide)
                                : ~joined_r;
endmodule

// *** logic/way_sram_host.sv ***
// Host controller driving the two-way or direct-mapped cache SRAM pins
`timescale 1ns/100ps
`include "way_sram_cfg.svh"
// Operation
// - Two-way: bank bit ignored, tied low
// - Write: chip select, bytes, way strobe low
// - Direct: write strobes joined, bank picks half
// - Read: select, bytes, enable low, write high
// - Direct: enables joined, bank picks half
module way_sram_host (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        req_valid,
   input  wire logic        req_write,
   input  wire logic        req_two_way,
   input  wire logic        req_way_b,
   input  wire logic        req_collide,
   input  wire logic [12:0] req_addr,
   input  wire logic [1:0]  req_byte_en,
   input  wire logic [15:0] req_wdata,
   output logic             req_ready,
   output logic             rsp_valid,
   output logic [15:0]      rsp_rdata,
   output logic [12:0]      sram_addr,
   output logic             address_latch_strobe,
   output logic             chip_select_master_n,
   output logic             low_byte_select_n,
   output logic             high_byte_select_n,
   output logic             way_a_write_strobe_n,
   output logic             way_b_write_strobe_n,
   output logic             way_a_output_enable_n,
   output logic             way_b_output_enable_n,
   output logic             mode,
   output logic [15:0]      data_out,
   output logic             data_oe_n,
   input  wire logic [15:0] data_in
);
   way_sram_pkg::state_type state;
   way_sram_pkg::state_type next_state;
   logic [`CNT_W-1:0]       cnt;
   logic [`CNT_W-1:0]       next_cnt;
   logic                    op_write;
   logic                    op_two_way;
   logic                    op_way_b;
   logic                    op_collide;
   logic [12:0]             op_addr;
   logic [1:0]              op_bytes;
   logic [15:0]             op_wdata;
   way_strobe_if            s ();

   // One-hot state decodes
   wire in_idle    = (state == way_sram_pkg::st_idle);
   wire in_setup   = (state == way_sram_pkg::st_setup);
   wire in_hold    = (state == way_sram_pkg::st_hold);
   wire in_read    = (state == way_sram_pkg::st_read);
   wire in_write   = (state == way_sram_pkg::st_write);
   wire in_release = (state == way_sram_pkg::st_release);
   wire cnt_done   = (cnt == '0);
   wire take       = in_idle & req_valid;
   wire active     = in_read | in_write;
   // Counter loads sit one below the cycle count, since zero ends a phase
   wire [`CNT_W-1:0] setup_load = `CNT_W'(`ADDR_SETUP_CYC - 1);
   wire [`CNT_W-1:0] hold_load  = `CNT_W'(`ADDR_HOLD_CYC - 1);
   wire [`CNT_W-1:0] acc_load   = `CNT_W'(`ACCESS_CYC - 1);
   wire [`CNT_W-1:0] wr_load    = `CNT_W'(`WRITE_PULSE_CYC - 1);
   // Two-way ignores the bank bit, so drive it to ground there
   wire [12:0] pin_addr = op_two_way ? {1'b0, op_addr[11:0]} : op_addr;
   wire [12:0] req_pin_addr = req_two_way ? {1'b0, req_addr[11:0]}
                                          : req_addr;
   // Address goes out on the take edge, a full cycle ahead of capture
   wire [12:0] next_addr = take ? req_pin_addr : pin_addr;
   wire [1:0]  pin_bytes_n = ~(op_bytes & {2{active}});
   // Latch closes once the address has settled, reopens on release
   wire next_latch_strobe = ~(in_setup & cnt_done) & ~in_hold
                            & ~active | in_release;
   // Chip select covers capture hold, access and pulse
   wire next_select_n     = ~(in_hold | active);
   // Host owns the bus only during the write pulse
   wire next_data_oe_n    = ~in_write;
   // Read data is taken on the last edge of the access window
   wire read_last         = in_read & cnt_done;

   // Sequencer view of the strobe decoder
   assign s.two_way  = op_two_way;
   assign s.way_b    = op_way_b;
   assign s.bank_bit = op_addr[`BANK_BIT];
   assign s.do_read  = in_read;
   assign s.do_write = in_write;
   assign s.collide  = in_read & op_collide & op_two_way;

   way_strobe_decode u_dec (
      .s (s)
   );

   // Next state and counter
   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      unique case (state)
         way_sram_pkg::st_idle: begin
            if (req_valid) begin
               next_state = way_sram_pkg::st_setup;
               next_cnt   = setup_load;
            end
         end
         way_sram_pkg::st_setup: begin
            // Address settles while latch is transparent
            if (cnt_done) begin
               next_state = way_sram_pkg::st_hold;
               next_cnt   = hold_load;
            end else begin
               next_cnt = cnt - 1'b1;
            end
         end
         way_sram_pkg::st_hold: begin
            // Strobe low captures address; keep it for hold time
            if (cnt_done) begin
               next_state = op_write ? way_sram_pkg::st_write
                                     : way_sram_pkg::st_read;
               next_cnt   = op_write ? wr_load : acc_load;
            end else begin
               next_cnt = cnt - 1'b1;
            end
         end
         way_sram_pkg::st_read,
         way_sram_pkg::st_write: begin
            if (cnt_done)
               next_state = way_sram_pkg::st_release;
            else
               next_cnt = cnt - 1'b1;
         end
         way_sram_pkg::st_release: begin
            next_state = way_sram_pkg::st_idle;
         end
      endcase
   end

   // State and captured request
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state      <= way_sram_pkg::st_idle;
         cnt        <= '0;
         op_write   <= 1'b0;
         op_two_way <= 1'b1;
         op_way_b   <= 1'b0;
         op_collide <= 1'b0;
         op_addr    <= '0;
         op_bytes   <= '0;
         op_wdata   <= '0;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
         if (take) begin
            op_write   <= req_write;
            op_two_way <= req_two_way;
            op_way_b   <= req_way_b;
            op_collide <= req_collide;
            op_addr    <= req_addr;
            op_bytes   <= req_byte_en;
            op_wdata   <= req_wdata;
         end
      end
   end

   // Pin registers; strobes rise together so write ends cleanly
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sram_addr             <= '0;
         address_latch_strobe  <= 1'b1;
         chip_select_master_n  <= 1'b1;
         low_byte_select_n     <= 1'b1;
         high_byte_select_n    <= 1'b1;
         way_a_write_strobe_n  <= 1'b1;
         way_b_write_strobe_n  <= 1'b1;
         way_a_output_enable_n <= 1'b1;
         way_b_output_enable_n <= 1'b1;
         mode                  <= 1'b1;
         data_out              <= '0;
         data_oe_n             <= 1'b1;
      end else begin
         sram_addr             <= next_addr;
         address_latch_strobe  <= next_latch_strobe;
         chip_select_master_n  <= next_select_n;
         low_byte_select_n     <= pin_bytes_n[0];
         high_byte_select_n    <= pin_bytes_n[1];
         way_a_write_strobe_n  <= s.we_n[0];
         way_b_write_strobe_n  <= s.we_n[1];
         way_a_output_enable_n <= s.oe_n[0];
         way_b_output_enable_n <= s.oe_n[1];
         mode                  <= op_two_way;
         data_out              <= op_wdata;
         data_oe_n             <= next_data_oe_n;
      end
   end

   // Handshake and read capture at end of access window
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
      end else begin
         req_ready <= (next_state == way_sram_pkg::st_idle);
         rsp_valid <= in_release;
         if (read_last)
            rsp_rdata <= data_in;
      end
   end
endmodule

// *** verification/sram_dev_model.sv ***
// Behavioural cache SRAM: two 4K ways behind an address latch
`timescale 1ns/100ps
module sram_dev_model #(
   parameter bit bank_bypass = 1'b0 // Fast variant: bank bit skips the latch
) (
   input  wire logic [12:0] sram_addr,
   input  wire logic        address_latch_strobe,
   input  wire logic        chip_select_master_n,
   input  wire logic        low_byte_select_n,
   input  wire logic        high_byte_select_n,
   input  wire logic        way_a_write_strobe_n,
   input  wire logic        way_b_write_strobe_n,
   input  wire logic        way_a_output_enable_n,
   input  wire logic        way_b_output_enable_n,
   input  wire logic        mode,
   input  wire logic [15:0] data_out,
   input  wire logic        data_oe_n,
   output logic      [15:0] data_in
);
   logic [15:0] mem [2][4096];
   logic [12:0] la;
   logic [1:0]  be, wr, rd, bank;
   logic        wa, wb, oa, ob, bank_bit;
   // Latch follows the pins while the strobe is high, holds after its fall
   always_latch if (address_latch_strobe) la <= sram_addr;
   // Active strobes, lanes only while selected, direct half by bank bit
   assign {wa, wb, oa, ob} = ~{way_a_write_strobe_n, way_b_write_strobe_n,
      way_a_output_enable_n, way_b_output_enable_n};
   assign be = {2{~chip_select_master_n}} &
      ~{high_byte_select_n, low_byte_select_n};
   // Fast variant routes the bank bit around the latch
   assign bank_bit = bank_bypass ? sram_addr[12] : la[12];
   assign bank = {bank_bit, ~bank_bit};
   assign wr = mode ? {wb, wa} : {2{wa & wb}} & bank;
   assign rd = mode ? {ob, oa} & {2{oa ^ ob}}
      : {2{oa & ob}} & bank;
   // Store enabled lanes while that way's write strobe is low; direct mode needs both strobes low
   always @* for (int w = 0; w < 2; w++) for (int b = 0; b < 2; b++)
      if (wr[w] && be[b]) mem[w][la[11:0]][8*b+:8] = data_out[8*b+:8];
   // Undriven lanes show the inverse of the host data, never a stale value
   for (genvar i = 0; i < 2; i++) begin : g_lane
      assign data_in[8*i+:8] = !data_oe_n ? data_out[8*i+:8]
         : (|rd && be[i]) ? mem[rd[1]][la[11:0]][8*i+:8]
         : ~data_out[8*i+:8];
   end
endmodule

// *** verification/way_sram_host_chk.sv ***
// Protocol assertions on the cache SRAM host pins
`timescale 1ns/100ps
module way_sram_host_chk (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        rsp_valid,
   input wire logic [12:0] sram_addr,
   input wire logic        address_latch_strobe,
   input wire logic        chip_select_master_n,
   input wire logic        way_a_write_strobe_n,
   input wire logic        way_b_write_strobe_n,
   input wire logic        way_a_output_enable_n,
   input wire logic        way_b_output_enable_n,
   input wire logic        mode,
   input wire logic        data_oe_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   logic w_on, r_on;
   // Any way write strobe or output enable active
   assign w_on = !(way_a_write_strobe_n && way_b_write_strobe_n);
   assign r_on = !(way_a_output_enable_n && way_b_output_enable_n);
   sequence write_pulse; w_on [*3] ##1 !w_on; endsequence
   sequence read_access; r_on [*5] ##1 !r_on; endsequence
   deselect_float_a: assert property (chip_select_master_n |-> data_oe_n)
      else $error("host drives bus while deselected");
   bank_grounded_a: assert property (
      mode && !chip_select_master_n |-> !sram_addr[12])
      else $error("bank bit high in two-way mode");
   direct_joined_a: assert property (!mode |->
      way_a_write_strobe_n == way_b_write_strobe_n &&
      way_a_output_enable_n == way_b_output_enable_n)
      else $error("way strobes differ in direct mode");
   write_exclusive_a: assert property (w_on |->
      !r_on && !data_oe_n && !chip_select_master_n)
      else $error("write strobe without select and bus drive");
   write_pulse_a: assert property ($rose(w_on) |-> write_pulse)
      else $error("write pulse length wrong");
   read_access_a: assert property ($rose(r_on) |-> read_access)
      else $error("read access length wrong");
   latch_first_a: assert property ($fell(chip_select_master_n) |->
      !address_latch_strobe && $stable(sram_addr))
      else $error("address not latched before select");
   answer_after_a: assert property ($fell(w_on || r_on) |-> rsp_valid)
      else $error("no response after strobes end");
endmodule
bind way_sram_host way_sram_host_chk chk (.*);

// *** verification/way_sram_host_tb.sv ***
// Self-checking bench for the cache SRAM host with a device model
`timescale 1ns/100ps
module way_sram_host_tb;
   typedef struct packed {
      logic w, tw, wb, col, chk;
      logic [12:0] a;
      logic [1:0] be;
      logic [15:0] d, e;
   } row_type;
   logic clk = 0, rstn = 0, req_valid = 0, req_write = 0, req_two_way = 0;
   logic req_way_b = 0, req_collide = 0, req_ready, rsp_valid, mode;
   logic [12:0] req_addr = 13'h0, sram_addr;
   logic [1:0] req_byte_en = 2'h0;
   logic [15:0] req_wdata = 16'h0, rsp_rdata, data_out, data_in;
   logic address_latch_strobe, chip_select_master_n, low_byte_select_n;
   logic high_byte_select_n, way_a_write_strobe_n, way_b_write_strobe_n;
   logic way_a_output_enable_n, way_b_output_enable_n, data_oe_n;
   int fail_count = 0, num_checks = 0;
   row_type rows [11] = '{
      '{1,1,0,0,0,13'h5,2'h3,16'h1234,16'h0},
      '{1,1,1,0,0,13'h5,2'h3,16'hABCD,16'h0},
      '{0,1,1,0,1,13'h5,2'h3,16'h0,16'hABCD},
      '{1,1,0,0,0,13'h5,2'h1,16'h5678,16'h0},
      '{0,1,0,0,1,13'h5,2'h3,16'h0,16'h1278},
      '{1,0,0,0,0,13'h1005,2'h3,16'h0F0F,16'h0},
      '{0,1,1,0,1,13'h5,2'h3,16'h0,16'h0F0F},
      '{0,0,0,0,1,13'h5,2'h3,16'h0,16'h1278},
      '{1,1,0,0,0,13'h1006,2'h3,16'h4444,16'h0},
      '{0,0,0,0,1,13'h6,2'h3,16'h0,16'h4444},
      '{0,1,0,1,1,13'h5,2'h3,16'h0,16'hFFFF}};
   way_sram_host uut (.*);
   sram_dev_model dev (.*);
   always #5 clk = ~clk;
   // Compare one value and log a mismatch
   task automatic check(string name, logic [15:0] exp, logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Present one request, hold it until taken, then await the answer
   task automatic run(row_type r);
      int n;
      n = 0;
      @(posedge clk);
      {req_write, req_two_way, req_way_b, req_collide} <= {r.w, r.tw, r.wb,
         r.col};
      {req_addr, req_byte_en, req_wdata} <= {r.a, r.be, r.d};
      req_valid <= 1;
      do @(negedge clk); while (!req_ready && ++n < 20);
      @(posedge clk);
      req_valid <= 0;
      do @(negedge clk); while (!rsp_valid && ++n < 40);
      check("rsp_valid", 16'h1, {15'h0, rsp_valid});
      if (r.chk) check("rsp_rdata", r.e, rsp_rdata);
   endtask
   // Print the verdict and stop
   task automatic finish_test();
      if (fail_count == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Watchdog far beyond the expected run length
   initial begin
      #20000;
      fail_count++;
      finish_test();
   end
   // Table pass, then a reset in mid-read and a read-back
   initial begin
      repeat (2) @(posedge clk);
      rstn <= 1;
      foreach (rows[i]) run(rows[i]);
      @(posedge clk);
      {req_valid, req_write} <= 2'h2;
      repeat (4) @(posedge clk);
      rstn <= 0;
      @(negedge clk);
      check("idle pins", 16'h03FF, {4'h0, req_ready, rsp_valid, data_oe_n,
         mode, address_latch_strobe, chip_select_master_n, low_byte_select_n,
         high_byte_select_n, way_a_write_strobe_n, way_b_write_strobe_n,
         way_a_output_enable_n, way_b_output_enable_n});
      @(posedge clk);
      rstn <= 1;
      req_valid <= 0;
      run(rows[4]);
      finish_test();
   end
endmodule
